// ### dv/dao_chk_sva.sv
// link checks between the converter and capture ends
`timescale 1ns/1ps
module dao_chk_sva
(
  // system
  input wire logic       i_sys_clk,
  input wire logic       i_rst_n,
  // link signals
  input wire logic       conv_clk,
  input wire logic       chan_a_output_disable_n,
  input wire logic       chan_b_output_disable_n,
  input wire logic       power_down_ctl,
  input wire logic [9:0] cha_data,
  input wire logic       cha_oe_n,
  input wire logic [9:0] chb_data,
  input wire logic       chb_oe_n
);
  default clocking dc @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  // pins float one cycle after the disable goes high
  property p_float_a;
    chan_a_output_disable_n |=> cha_oe_n;
  endproperty
  a_float_a: assert property (p_float_a)
    else $error("channel a still driven");

  property p_drive_a;
    !chan_a_output_disable_n |=> !cha_oe_n;
  endproperty
  a_drive_a: assert property (p_drive_a)
    else $error("channel a not driven");

  property p_oe_b;
    1'b1 |=> chb_oe_n == $past(chan_b_output_disable_n);
  endproperty
  a_oe_b: assert property (p_oe_b)
    else $error("channel b enable mismatch");

  // a settled power-down forces the marker word on both channels
  property p_pd_bad;
    power_down_ctl ##1 power_down_ctl |=>
      cha_data == dao_pkg::CORRUPT_WORD && chb_data == dao_pkg::CORRUPT_WORD;
  endproperty
  a_pd_bad: assert property (p_pd_bad)
    else $error("word not corrupt in power-down");

  // pipeline still holds spoiled samples right after release
  property p_pd_exit;
    $fell(power_down_ctl) |-> (cha_data == dao_pkg::CORRUPT_WORD)[*8];
  endproperty
  a_pd_exit: assert property (p_pd_exit)
    else $error("good word too soon after power-down");

  // real words only change in the cycle after a clock rise
  property p_rise_a;
    !$stable(cha_data) && cha_data != dao_pkg::CORRUPT_WORD |->
      $past(conv_clk) && !$past(conv_clk, 2);
  endproperty
  a_rise_a: assert property (p_rise_a)
    else $error("channel a word off the clock rise");

  property p_rise_b;
    !$stable(chb_data) && chb_data != dao_pkg::CORRUPT_WORD |->
      $past(conv_clk) && !$past(conv_clk, 2);
  endproperty
  a_rise_b: assert property (p_rise_b)
    else $error("channel b word off the clock rise");

  // sampling clock never stalls: two high, two low, repeat
  property p_clk;
    $rose(conv_clk) |=> conv_clk ##1 !conv_clk [*2] ##1 conv_clk;
  endproperty
  a_clk: assert property (p_clk)
    else $error("sampling clock shape wrong");
endmodule

// ### dv/tb_top.sv
// self-checking bench joining both ends of the converter link
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("wrong value at %0t: got %h exp %h", $time, got, exp); \
    end \
  end
module tb_top;
  logic                sys_clk;
  logic                rst_n;
  logic signed [11:0]  a_pos, a_neg, b_pos, b_neg;
  logic                pd_req, ena, enb;
  dao_pkg::dao_sel_t   fmt_sel;
  logic [9:0]          cw, dw;
  logic                cv, dv, rdy, duty_ok, stale2, primed2, duty2;
  int                  error_cnt, checks_done, cyc;
  logic signed [11:0]  lvl_d [5] = '{-256, -128, 0, 128, 256};
  logic signed [11:0]  lvl_s [5] = '{-512, -256, 0, 256, 512};
  logic [9:0]          codes [5] = '{10'h000, 10'h100, 10'h200,
                                     10'h300, 10'h3FF};
  logic [9:0]          codes_tc [5] = '{10'h200, 10'h300, 10'h000,
                                        10'h100, 10'h1FF};
  dao_pkg::dao_sel_t   sels  [4] = '{dao_pkg::SEL_SUPPLY, dao_pkg::SEL_GROUND,
                                     dao_pkg::SEL_MID, dao_pkg::SEL_FLOAT};
  logic                twos  [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

  dao_if lnk_if();
  dao_if lnk2_if();
  // pin levels of channel b as the board would see them
  wire [9:0]           chb_pins = lnk_if.chb_oe_n ? 10'hZZZ : lnk_if.chb_data;

  dao_conv dao_conv_i (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
    .i_analog_in_a_pos(a_pos), .i_analog_in_a_neg(a_neg),
    .i_analog_in_b_pos(b_pos), .i_analog_in_b_neg(b_neg),
    .o_duty_ok(duty_ok), .o_clk_stale(), .o_pipe_primed(), .lnk(lnk_if));
  dao_capture #(.RECOVERY_CYC(50)) dao_capture_i (.i_sys_clk(sys_clk),
    .i_rst_n(rst_n), .i_power_down_req(pd_req), .i_format_sel(fmt_sel),
    .i_cha_enable(ena), .i_chb_enable(enb), .o_cha_word(cw),
    .o_cha_valid(cv), .o_chb_word(dw), .o_chb_valid(dv), .o_ready(rdy),
    .lnk(lnk_if));
  // second converter faces a bench driver that stalls its clock
  dao_conv dao_conv_i2 (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
    .i_analog_in_a_pos(a_pos), .i_analog_in_a_neg(a_neg),
    .i_analog_in_b_pos(b_pos), .i_analog_in_b_neg(b_neg),
    .o_duty_ok(duty2), .o_clk_stale(stale2), .o_pipe_primed(primed2),
    .lnk(lnk2_if));
  dao_chk_sva dao_chk_sva_i (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
    .conv_clk(lnk_if.conv_clk),
    .chan_a_output_disable_n(lnk_if.chan_a_output_disable_n),
    .chan_b_output_disable_n(lnk_if.chan_b_output_disable_n),
    .power_down_ctl(lnk_if.power_down_ctl), .cha_data(lnk_if.cha_data),
    .cha_oe_n(lnk_if.cha_oe_n), .chb_data(lnk_if.chb_data),
    .chb_oe_n(lnk_if.chb_oe_n));

  // 200 MHz system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic print_verdict;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // hang guard, far above the roughly 1750 cycles the run needs
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      error_cnt++;
      $display("wrong value at %0t: timeout", $time);
      print_verdict();
    end
  end

  task automatic wait_valid(input bit b);
    int n;
    n = 0;
    tick();
    while (((b ? dv : cv) !== 1'b1) && n < 40)
    begin
      tick();
      n++;
    end
    `CHK(n < 40, 1'b1)
  endtask

  // set levels and format, then compare both captured words
  task automatic apply(input int s, input int l);
    int v;
    logic [9:0] e;
    v = 0;
    a_pos = lvl_d[l];
    a_neg = -lvl_d[l];
    b_pos = lvl_s[l];
    b_neg = 12'sh000;
    if (fmt_sel != sels[s])
    begin
      fmt_sel = sels[s];
      repeat (28)
      begin
        tick();
        v += int'(cv !== 1'b0);
      end
      `CHK(v, 0)
    end
    // latency plus the settle window, all in capture periods
    repeat ((dao_pkg::PIPE_LAT + dao_pkg::FMT_DISCARD + 2) * 4) tick();
    e = twos[s] ? codes_tc[l] : codes[l];
    wait_valid(1'b0);
    `CHK(cw, e)
    `CHK(dw, e)
  endtask

  // main sequence
  initial
  begin
    int n;
    int v;
    {a_pos, a_neg, b_pos, b_neg} = '0;
    {pd_req, ena, enb, rst_n} = 4'h6;
    fmt_sel = dao_pkg::SEL_SUPPLY;
    lnk2_if.conv_clk = 1'b0;
    lnk2_if.chan_a_output_disable_n = 1'b0;
    lnk2_if.chan_b_output_disable_n = 1'b0;
    lnk2_if.power_down_ctl = 1'b0;
    lnk2_if.format_stabilizer_select = dao_pkg::SEL_SUPPLY;
    repeat (3) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    n = 0;
    while (rdy !== 1'b1 && n < 200)
    begin
      tick();
      n++;
    end
    `CHK(duty_ok, 1'b1)
    for (int s = 0; s < 4; s++)
      for (int l = 0; l < 5; l++)
        apply(s, l);
    // channel b floated while its converter keeps running
    enb = 1'b0;
    repeat (3) tick();
    `CHK(chb_pins, 10'hZZZ)
    b_pos = lvl_s[1];
    repeat (40) tick();
    enb = 1'b1;
    repeat (8) tick();
    wait_valid(1'b1);
    `CHK(dw, 10'h100)
    // power-down, then the recovery wait before words are trusted
    pd_req = 1'b1;
    repeat (10) tick();
    `CHK(lnk_if.cha_data, dao_pkg::CORRUPT_WORD)
    `CHK(rdy, 1'b0)
    pd_req = 1'b0;
    n = 0;
    v = 0;
    while (rdy !== 1'b1 && n < 200)
    begin
      tick();
      n++;
      v += int'(cv !== 1'b0);
    end
    `CHK(v, 0)
    `CHK(n >= 50 && n <= 60, 1'b1)
    wait_valid(1'b0);
    `CHK(cw, 10'h3FF)
    // second converter: clean clock, then a stall
    for (int i = 0; i < 48; i++)
    begin
      lnk2_if.conv_clk = (i % 4) < 2;
      tick();
    end
    `CHK(primed2, 1'b1)
    `CHK(lnk2_if.cha_data, 10'h3FF)
    lnk2_if.conv_clk = 1'b0;
    repeat (20) tick();
    `CHK(stale2, 1'b1)
    `CHK(lnk2_if.cha_data, dao_pkg::CORRUPT_WORD)
    // quarter duty: outside the narrow window, inside the wide one
    lnk2_if.format_stabilizer_select = dao_pkg::SEL_FLOAT;
    for (int i = 0; i < 16; i++)
    begin
      lnk2_if.conv_clk = (i % 4) < 1;
      tick();
    end
    `CHK(duty2, 1'b0)
    lnk2_if.format_stabilizer_select = dao_pkg::SEL_SUPPLY;
    repeat (2) tick();
    `CHK(duty2, 1'b1)
    print_verdict();
  end
endmodule

// ### hw/dao_capture.sv
// capture end: makes the sampling clock, drives controls, latches words
`timescale 1ns/1ps
module dao_capture
#(
  parameter int RECOVERY_CYC = dao_pkg::RECOVERY_CYC
)
(
  // system
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  // user controls
  input  wire logic              i_power_down_req,
  input  wire dao_pkg::dao_sel_t i_format_sel,
  input  wire logic              i_cha_enable,
  input  wire logic              i_chb_enable,
  // captured samples
  output logic [9:0]             o_cha_word,
  output logic                   o_cha_valid,
  output logic [9:0]             o_chb_word,
  output logic                   o_chb_valid,
  output logic                   o_ready,
  // link to the converter
  dao_if.cap                     lnk
);

  typedef enum logic [1:0]
  {
    CP_OFF    = 2'b00,
    CP_WAKE   = 2'b01,
    CP_RUN    = 2'b11,
    CP_SETTLE = 2'b10
  } dao_cp_t;

  localparam logic [1:0]  DIV_LAST = 2'(dao_pkg::CONV_DIV_CYC - 1);
  localparam logic [1:0]  DIV_HIGH = 2'(dao_pkg::CONV_HIGH_CYC);
  localparam logic [3:0]  DISC_LAST = 4'(dao_pkg::FMT_DISCARD - 1);
  localparam logic [16:0] WAKE_LAST = 17'(RECOVERY_CYC - 1);

  dao_cp_t            st_r;
  dao_cp_t            st_nxt;
  logic [1:0]         div_r;
  logic               clk_r;
  logic               cap;
  logic               take_a;
  logic               take_b;
  logic               sel_chg;
  logic [16:0]        wake_r;
  logic [3:0]         disc_r;
  logic               pd_r;
  logic               ena_r;
  logic               enb_r;
  dao_pkg::dao_sel_t  sel_r;

  // free-running divide by four, 50 MHz, never paused
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      div_r <= 2'd0;
      clk_r <= 1'b1;
    end
    else
    begin
      div_r <= (div_r == DIV_LAST) ? 2'd0 : div_r + 2'd1;
      clk_r <= (div_r == DIV_LAST) || (div_r + 2'd1 < DIV_HIGH);
    end
  end

  // latch late in the period, well after the converter updates
  assign cap     = (div_r == DIV_LAST);
  assign sel_chg = (i_format_sel != sel_r);

  // a floating channel is never latched, its pins hold no word
  assign take_a  = cap && ena_r && !lnk.cha_oe_n;
  assign take_b  = cap && enb_r && !lnk.chb_oe_n;

  // control pins registered straight from the user side
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      pd_r  <= 1'b1;
      ena_r <= 1'b0;
      enb_r <= 1'b0;
      sel_r <= dao_pkg::SEL_SUPPLY;
    end
    else
    begin
      pd_r  <= i_power_down_req;
      ena_r <= i_cha_enable;
      enb_r <= i_chb_enable;
      sel_r <= i_format_sel;
    end
  end

  // trust state: recovery after power-down, discard after select change
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      CP_OFF:
        if (!pd_r)
          st_nxt = CP_WAKE;
      CP_WAKE:
        if (pd_r)
          st_nxt = CP_OFF;
        else if (wake_r == WAKE_LAST)
          st_nxt = CP_RUN;
      CP_RUN:
        if (pd_r)
          st_nxt = CP_OFF;
        else if (sel_chg)
          st_nxt = CP_SETTLE;
      CP_SETTLE:
        if (pd_r)
          st_nxt = CP_OFF;
        else if (cap && disc_r == DISC_LAST && !sel_chg)
          st_nxt = CP_RUN;
      default:
        st_nxt = CP_OFF;
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      st_r <= CP_OFF;
    else
      st_r <= st_nxt;
  end

  // recovery counter, a parameter so simulation can shorten it
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || st_r != CP_WAKE)
      wake_r <= 17'd0;
    else
      wake_r <= wake_r + 17'd1;
  end

  // discarded captures; a further change restarts the count
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || st_r != CP_SETTLE || sel_chg)
      disc_r <= 4'd0;
    else if (cap)
      disc_r <= disc_r + 4'd1;
  end

  // words latched each period the channel is enabled and driven; valid only when trusted and enabled
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_cha_word  <= 10'h000;
      o_chb_word  <= 10'h000;
      o_cha_valid <= 1'b0;
      o_chb_valid <= 1'b0;
      o_ready     <= 1'b0;
    end
    else
    begin
      if (take_a)
        o_cha_word <= lnk.cha_data;
      if (take_b)
        o_chb_word <= lnk.chb_data;
      o_cha_valid <= take_a && st_r == CP_RUN && !sel_chg;
      o_chb_valid <= take_b && st_r == CP_RUN && !sel_chg;
      o_ready     <= (st_r == CP_RUN);
    end
  end

  assign lnk.conv_clk                 = clk_r;
  assign lnk.power_down_ctl           = pd_r;
  assign lnk.chan_a_output_disable_n  = !ena_r;
  assign lnk.chan_b_output_disable_n  = !enb_r;
  assign lnk.format_stabilizer_select = sel_r;
endmodule

// ### hw/dao_conv.sv
// converter end: sampling, code mapping, latency pipeline and output drive
`timescale 1ns/1ps
module dao_conv
(
  // system
  input  wire logic               i_sys_clk,
  input  wire logic               i_rst_n,
  // channel a analog levels, one count per 512th of reference
  input  wire logic signed [11:0] i_analog_in_a_pos,
  input  wire logic signed [11:0] i_analog_in_a_neg,
  // channel b analog levels
  input  wire logic signed [11:0] i_analog_in_b_pos,
  input  wire logic signed [11:0] i_analog_in_b_neg,
  // status
  output logic                    o_duty_ok,
  output logic                    o_clk_stale,
  output logic                    o_pipe_primed,
  // link to the capture logic
  dao_if.conv                     lnk
);

  typedef enum logic [1:0]
  {
    DV_RUN    = 2'b00,
    DV_DOWN   = 2'b01,
    DV_REFILL = 2'b11
  } dao_dv_t;

  localparam logic [7:0] STALE_LIM = 8'(dao_pkg::CONV_PER_MAX_CYC);
  localparam logic [2:0] FILL_LAST = 3'(dao_pkg::PIPE_LAT);

  dao_dv_t     st_r;
  dao_dv_t     st_nxt;
  logic        clk_q_r;
  logic        rise;
  logic [7:0]  hi_cnt_r;
  logic [7:0]  per_cnt_r;
  logic [7:0]  hi_meas_r;
  logic [7:0]  per_meas_r;
  logic [2:0]  fill_r;
  logic        stale;
  logic        pd;
  logic        flush;
  logic        dcs;
  logic        twos;
  logic        duty_ok;
  logic        bad_in;
  logic [9:0]  ob_a;
  logic [9:0]  ob_b;
  logic [9:0]  code_a;
  logic [9:0]  code_b;
  logic [9:0]  pa_word;
  logic [9:0]  pb_word;
  logic        pa_bad;
  logic        pb_bad;
  logic [9:0]  cha_data_r;
  logic [9:0]  chb_data_r;
  logic        cha_oe_n_r;
  logic        chb_oe_n_r;

  // sampling instant is the rising edge of the conversion clock
  assign rise = lnk.conv_clk && !clk_q_r;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      clk_q_r <= 1'b1; // no false edge right after release
    else
      clk_q_r <= lnk.conv_clk;
  end

  // period and high-time counters, saturating so a stopped clock is seen
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      per_cnt_r <= 8'h00;
      hi_cnt_r  <= 8'h00;
    end
    else if (rise)
    begin
      per_cnt_r <= 8'h01;
      hi_cnt_r  <= 8'h01;
    end
    else
    begin
      if (per_cnt_r != 8'hFF)
        per_cnt_r <= per_cnt_r + 8'h01;
      if (lnk.conv_clk && hi_cnt_r != 8'hFF)
        hi_cnt_r <= hi_cnt_r + 8'h01;
    end
  end

  // last full period, held until the next edge
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      per_meas_r <= 8'h00;
      hi_meas_r  <= 8'h00;
    end
    else if (rise)
    begin
      per_meas_r <= per_cnt_r;
      hi_meas_r  <= hi_cnt_r;
    end
  end

  // select pin decode; a change takes effect on new samples only, so
  // older words in flight keep the old format for a few clocks
  assign dcs  = dao_pkg::dcs_on(lnk.format_stabilizer_select);
  assign twos = dao_pkg::twos_fmt(lnk.format_stabilizer_select);

  // stabilizer widens the usable duty window; without it the window
  // is narrow and samples outside it are not trusted
  assign duty_ok = dcs ?
    dao_pkg::duty_in(hi_meas_r, per_meas_r,
                     dao_pkg::DCS_ON_MIN_PCT, dao_pkg::DCS_ON_MAX_PCT) :
    dao_pkg::duty_in(hi_meas_r, per_meas_r,
                     dao_pkg::DCS_OFF_MIN_PCT, dao_pkg::DCS_OFF_MAX_PCT);

  // internal charge decays if the clock stalls or runs too slow
  assign stale = per_cnt_r > STALE_LIM;

  // power-down and a stale clock both spoil everything in flight
  assign pd     = lnk.power_down_ctl;
  assign flush  = pd || stale || (st_r == DV_DOWN);
  assign bad_in = flush || !duty_ok;

  // code mapping, same formula for differential and single-ended drive
  assign ob_a   = dao_pkg::ob_code(i_analog_in_a_pos,
                                   i_analog_in_a_neg);
  assign ob_b   = dao_pkg::ob_code(i_analog_in_b_pos,
                                   i_analog_in_b_neg);
  assign code_a = twos ? {~ob_a[9], ob_a[8:0]} : ob_a;
  assign code_b = twos ? {~ob_b[9], ob_b[8:0]} : ob_b;

  // both channels advance on every edge, enabled or not
  dao_pipe u_pipe_a
  (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_adv     (rise),
    .i_flush   (flush),
    .i_word    (code_a),
    .i_bad     (bad_in),
    .o_word    (pa_word),
    .o_bad     (pa_bad)
  );

  dao_pipe u_pipe_b
  (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_adv     (rise),
    .i_flush   (flush),
    .i_word    (code_b),
    .i_bad     (bad_in),
    .o_word    (pb_word),
    .o_bad     (pb_bad)
  );

  // power state: down while asserted, then refill the pipeline
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      DV_RUN:
        if (pd)
          st_nxt = DV_DOWN;
      DV_DOWN:
        if (!pd)
          st_nxt = DV_REFILL;
      DV_REFILL:
        if (pd)
          st_nxt = DV_DOWN;
        else if (rise && fill_r == FILL_LAST - 3'd1)
          st_nxt = DV_RUN;
      default:
        st_nxt = DV_DOWN;
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      st_r <= DV_DOWN;
    else
      st_r <= st_nxt;
  end

  // edges seen since power-down release
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || st_r != DV_REFILL)
      fill_r <= 3'd0;
    else if (rise)
      fill_r <= fill_r + 3'd1;
  end

  // output word follows the seventh stage, one word per edge
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || flush)
    begin
      cha_data_r <= dao_pkg::CORRUPT_WORD;
      chb_data_r <= dao_pkg::CORRUPT_WORD;
    end
    else if (rise)
    begin
      cha_data_r <= pa_bad ? dao_pkg::CORRUPT_WORD : pa_word;
      chb_data_r <= pb_bad ? dao_pkg::CORRUPT_WORD : pb_word;
    end
  end

  // disable high floats the channel's pins, low drives them
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      cha_oe_n_r <= 1'b1;
      chb_oe_n_r <= 1'b1;
    end
    else
    begin
      cha_oe_n_r <= lnk.chan_a_output_disable_n;
      chb_oe_n_r <= lnk.chan_b_output_disable_n;
    end
  end

  // status flops
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_duty_ok     <= 1'b0;
      o_clk_stale   <= 1'b0;
      o_pipe_primed <= 1'b0;
    end
    else
    begin
      o_duty_ok     <= duty_ok;
      o_clk_stale   <= stale;
      o_pipe_primed <= (st_r == DV_RUN);
    end
  end

  assign lnk.cha_data = cha_data_r;
  assign lnk.chb_data = chb_data_r;
  assign lnk.cha_oe_n = cha_oe_n_r;
  assign lnk.chb_oe_n = chb_oe_n_r;
endmodule

// ### hw/dao_if.sv
// link between the converter and the capture logic
`timescale 1ns/1ps
interface dao_if;
  logic                  conv_clk;
  logic                  chan_a_output_disable_n;
  logic                  chan_b_output_disable_n;
  logic                  power_down_ctl;
  dao_pkg::dao_sel_t     format_stabilizer_select;
  logic [9:0]            cha_data;
  logic                  cha_oe_n;
  logic [9:0]            chb_data;
  logic                  chb_oe_n;
  // a channel's pins float while its oe_n is high; capture must only
  // trust the words while oe_n is low

  modport conv
  (
    input  conv_clk, chan_a_output_disable_n, chan_b_output_disable_n,
    input  power_down_ctl, format_stabilizer_select,
    output cha_data, cha_oe_n, chb_data, chb_oe_n
  );

  modport cap
  (
    output conv_clk, chan_a_output_disable_n, chan_b_output_disable_n,
    output power_down_ctl, format_stabilizer_select,
    input  cha_data, cha_oe_n, chb_data, chb_oe_n
  );
endinterface

// ### hw/dao_pipe.sv
// conversion pipeline of one channel, word plus corrupt flag per stage
`timescale 1ns/1ps
module dao_pipe
(
  // system
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  // control
  input  wire logic       i_adv,
  input  wire logic       i_flush,
  // sample in
  input  wire logic [9:0] i_word,
  input  wire logic       i_bad,
  // oldest stage
  output logic      [9:0] o_word,
  output logic            o_bad
);
  logic [9:0]                   word_r [dao_pkg::PIPE_LAT];
  logic [dao_pkg::PIPE_LAT-1:0] bad_r;

  // words need no reset: a set bad flag masks them
  always_ff @(posedge i_sys_clk)
  begin
    if (i_adv)
    begin
      word_r[0] <= i_word;
      for (int i = 1; i < dao_pkg::PIPE_LAT; i++)
        word_r[i] <= word_r[i-1];
    end
  end

  // flush marks every stage so stored charge is never trusted
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || i_flush)
      bad_r <= '1;
    else if (i_adv)
      bad_r <= {bad_r[dao_pkg::PIPE_LAT-2:0], i_bad};
  end

  assign o_word = word_r[dao_pkg::PIPE_LAT-1];
  assign o_bad  = bad_r[dao_pkg::PIPE_LAT-1];
endmodule

// ### hw/dao_pkg.sv
// shared constants, types and helpers for the dual converter output control
package dao_pkg;

  // data path
  localparam int         WORD_W       = 10;
  localparam int         AIN_W        = 12;
  localparam int         PIPE_LAT     = 7;
  localparam logic [9:0] MID_CODE     = 10'h200;
  localparam logic [9:0] MAX_CODE     = 10'h3FF;
  localparam logic [9:0] CORRUPT_WORD = 10'h2AA;

  // clock rates in MHz and derived periods in system cycles
  localparam int SYS_MHZ          = 200;
  localparam int CONV_MIN_MHZ     = 15;
  localparam int CONV_MAX_MHZ     = 65;
  localparam int CONV_PER_MIN_CYC = (SYS_MHZ + CONV_MAX_MHZ - 1) / CONV_MAX_MHZ;
  localparam int CONV_PER_MAX_CYC = SYS_MHZ / CONV_MIN_MHZ;
  localparam int CONV_DIV_CYC     = 4;
  localparam int CONV_HIGH_CYC    = 2;

  // duty windows in percent, with and without the stabilizer
  localparam int DCS_ON_MIN_PCT  = 20;
  localparam int DCS_ON_MAX_PCT  = 80;
  localparam int DCS_OFF_MIN_PCT = 40;
  localparam int DCS_OFF_MAX_PCT = 60;

  // recovery and settling
  localparam int RECOVERY_US  = 500;
  localparam int RECOVERY_CYC = RECOVERY_US * SYS_MHZ;
  localparam int FMT_DISCARD  = 8;

  // four-level select pin as seen by logic
  typedef enum logic [1:0]
  {
    SEL_GROUND = 2'h0,
    SEL_MID    = 2'h1,
    SEL_FLOAT  = 2'h2,
    SEL_SUPPLY = 2'h3
  } dao_sel_t;

  // offset-binary code, one count per 512th of the reference, clipped
  function automatic logic [9:0] ob_code(input logic signed [11:0] pos,
                                         input logic signed [11:0] neg);
    logic signed [13:0] sum;
    sum = 14'(pos) - 14'(neg) + 14'sh200;
    if (sum < 0)
      return 10'h000;
    else if (sum > 14'sh3FF)
      return MAX_CODE;
    else
      return sum[9:0];
  endfunction

  function automatic logic twos_fmt(input dao_sel_t sel);
    return (sel == SEL_GROUND) || (sel == SEL_MID);
  endfunction

  function automatic logic dcs_on(input dao_sel_t sel);
    return (sel == SEL_GROUND) || (sel == SEL_SUPPLY);
  endfunction

  // high time as share of period within [lo, hi] percent
  function automatic logic duty_in(input logic [7:0] hi_cyc,
                                   input logic [7:0] per_cyc,
                                   input int lo, input int hi);
    logic [15:0] h100;
    h100 = 16'(hi_cyc) * 16'd100;
    return (h100 >= 16'(per_cyc) * 16'(lo)) &&
           (h100 <= 16'(per_cyc) * 16'(hi));
  endfunction

endpackage
